/* accel_config_status_regs.sv */
// Purpose: AHB-Lite register bank for accelerometer fill count, FIFO port, status and config
// Assumes: single AHB-Lite slave, zero wait states, FIFO source presents its head byte
// Notes: registers are one byte each in the low lane of an aligned word
//
// Contract
// - fill count is 14 bits over two bytes
// - one read port streams successive FIFO bytes
// - status low five bits carry init message
// - status bit 5 flags bad axis remapping
// - status bit 6 flags rate too low for 50Hz
// - status bit 7 flags rate too low for tap
// - rate field selects 25/32 Hz to 1600 Hz
// - rate applies whatever the power mode
// - continuous mode bandwidth picks OSR4, OSR2, normal
// - averaging mode averages two to the code samples
// - bit 7 picks averaging or continuous filter
// - range field picks 2/4/8/16 g, resets 4g
// - rate config resets to 0xA8
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module accel_config_status_regs #(
  parameter logic [3:0] TAP_MIN_CODE = 4'h9
) (
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [accel_regs_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [accel_regs_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [accel_regs_pkg::DATA_W-1:0] hrdata,
  // FIFO engine side
  input wire logic [accel_regs_pkg::FILL_W-1:0] fifo_fill_level,
  input wire logic [accel_regs_pkg::BYTE_W-1:0] fifo_head_byte,
  input wire logic fifo_head_valid,
  output logic fifo_pop,
  // feature engine and core state
  input wire logic [accel_regs_pkg::BYTE_W-1:0] activity_code,
  input wire logic [accel_regs_pkg::MSG_W-1:0] status_msg,
  input wire logic remap_fault,
  input wire logic feature_50hz_en,
  input wire logic tap_en,
  // configuration to the sensing path
  output logic [accel_regs_pkg::ODR_W-1:0] odr_sel,
  output logic odr_code_reserved,
  output logic perf_mode,
  output logic [accel_regs_pkg::BWP_W-1:0] bwp_sel,
  output accel_regs_pkg::filter_mode_t filter_mode,
  output logic [accel_regs_pkg::BWP_W-1:0] avg_log2,
  output logic [accel_regs_pkg::RANGE_W-1:0] range_sel
);
  import accel_regs_pkg::*;

  // address phase capture for the write data phase
  logic wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;

  // configuration storage
  logic [BYTE_W-1:0] rate_cfg_q;
  logic [BYTE_W-1:0] rate_cfg_d;
  logic [RANGE_W-1:0] range_q;
  logic [RANGE_W-1:0] range_d;

  // read path
  logic [BYTE_W-1:0] rd_byte;
  logic [DATA_W-1:0] hrdata_q;
  logic [BYTE_W-1:0] status_byte;

  // decoded configuration, registered
  logic odr_reserved_q;
  filter_mode_t filter_mode_q;
  logic [BWP_W-1:0] avg_log2_q;

  logic xfer_ok;
  logic rd_accept;
  logic wr_accept;
  logic port_read;

  // true when a byte address hits a given register index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == reg_addr(idx));
  endfunction

  // reserved rate codes sit at both ends of the table
  function automatic logic odr_is_reserved(input logic [ODR_W-1:0] code);
    odr_is_reserved = (code < ODR_MIN_CODE) || (code > ODR_MAX_CODE);
  endfunction

  // the bus sees a single zero-wait slave that never errors
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_q;

  // a transfer is taken in its address phase when the bus is ready
  assign xfer_ok = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
  assign rd_accept = xfer_ok && !hwrite;
  assign wr_accept = xfer_ok && hwrite;

  // each accepted read of the port consumes one head byte when the head is valid
  assign port_read = rd_accept && hit(haddr, IDX_FIFO_PORT);
  assign fifo_pop = port_read && fifo_head_valid;

  // remember the write target until its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= wr_accept;
      if (wr_accept) begin
        wr_addr_q <= haddr;
      end
    end
  end

  // only the two config registers take writes; all else is dropped
  always_comb begin
    rate_cfg_d = rate_cfg_q;
    range_d = range_q;
    if (wr_pend_q && hit(wr_addr_q, IDX_RATE_CFG)) begin
      rate_cfg_d = hwdata[BYTE_W-1:0];
    end
    if (wr_pend_q && hit(wr_addr_q, IDX_RANGE)) begin
      range_d = hwdata[RANGE_W-1:0];
    end
  end

  // rate/filter configuration register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_cfg_q <= RATE_CFG_RESET;
    end else begin
      rate_cfg_q <= rate_cfg_d;
    end
  end

  // full-scale range register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_q <= RANGE_RESET;
    end else begin
      range_q <= range_d;
    end
  end

  // status flags are judged against the live rate setting
  config_fault_eval #(
    .TAP_MIN_CODE(TAP_MIN_CODE)
  ) u_fault_eval (
    .hclk(hclk),
    .hresetn(hresetn),
    .odr_code(rate_cfg_q[ODR_LSB +: ODR_W]),
    .status_msg(status_msg),
    .remap_fault(remap_fault),
    .feature_50hz_en(feature_50hz_en),
    .tap_en(tap_en),
    .status_q(status_byte)
  );

  // read mux forwards a write in flight so back-to-back write/read is coherent
  always_comb begin
    rd_byte = BYTE_ZERO;
    if (hit(haddr, IDX_FILL_LO)) begin
      rd_byte = fifo_fill_level[BYTE_W-1:0];
    end else if (hit(haddr, IDX_FILL_HI)) begin
      rd_byte = {2'b00, fifo_fill_level[FILL_W-1:BYTE_W]};
    end else if (hit(haddr, IDX_FIFO_PORT)) begin
      rd_byte = fifo_head_valid ? fifo_head_byte : BYTE_ZERO;
    end else if (hit(haddr, IDX_ACTIVITY)) begin
      rd_byte = activity_code;
    end else if (hit(haddr, IDX_STATUS)) begin
      rd_byte = status_byte;
    end else if (hit(haddr, IDX_RATE_CFG)) begin
      rd_byte = rate_cfg_d;
    end else if (hit(haddr, IDX_RANGE)) begin
      rd_byte = {{(BYTE_W-RANGE_W){1'b0}}, range_d};
    end
  end

  // read data is latched at the address phase edge, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (rd_accept) begin
      hrdata_q <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
    end
  end

  // filter decode: continuous mode uses the low three codes, others reserved
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_mode_q <= FILT_NORMAL;
      avg_log2_q <= '0;
    end else if (rate_cfg_d[PERF_BIT]) begin
      avg_log2_q <= '0;
      unique case (rate_cfg_d[BWP_LSB +: BWP_W])
        BWP_OSR4: filter_mode_q <= FILT_OSR4;
        BWP_OSR2: filter_mode_q <= FILT_OSR2;
        BWP_NORMAL: filter_mode_q <= FILT_NORMAL;
        default: filter_mode_q <= FILT_RESERVED;
      endcase
    end else begin
      filter_mode_q <= FILT_AVERAGE;
      avg_log2_q <= rate_cfg_d[BWP_LSB +: BWP_W];
    end
  end

  // rate code check; the code passes through whatever the power mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      odr_reserved_q <= 1'b0;
    end else begin
      odr_reserved_q <= odr_is_reserved(rate_cfg_d[ODR_LSB +: ODR_W]);
    end
  end

  // configuration outputs come straight from the registers
  assign odr_sel = rate_cfg_q[ODR_LSB +: ODR_W];
  assign odr_code_reserved = odr_reserved_q;
  assign perf_mode = rate_cfg_q[PERF_BIT];
  assign bwp_sel = rate_cfg_q[BWP_LSB +: BWP_W];
  assign filter_mode = filter_mode_q;
  assign avg_log2 = avg_log2_q;
  assign range_sel = range_q;

  // hsize is accepted but only the low byte lane carries register data
  logic unused_size;
  assign unused_size = ^hsize;

endmodule // accel_config_status_regs

/* accel_regs_pkg.sv */
// Purpose: shared constants for the accelerometer configuration and status register bank
// Assumes: register indices are byte-wide slots placed one per 32-bit AHB word
// Notes: byte address of a register is four times its index
package accel_regs_pkg;

  // bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // register indices
  localparam logic [7:0] IDX_FILL_LO = 8'h24;
  localparam logic [7:0] IDX_FILL_HI = 8'h25;
  localparam logic [7:0] IDX_FIFO_PORT = 8'h26;
  localparam logic [7:0] IDX_ACTIVITY = 8'h27;
  localparam logic [7:0] IDX_STATUS = 8'h2A;
  localparam logic [7:0] IDX_RATE_CFG = 8'h40;
  localparam logic [7:0] IDX_RANGE = 8'h41;

  // reset values
  localparam logic [7:0] RATE_CFG_RESET = 8'hA8;
  localparam logic [1:0] RANGE_RESET = 2'h1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // field layout of the rate/filter configuration byte, and the range field width
  localparam int ODR_LSB = 0;
  localparam int ODR_W = 4;
  localparam int BWP_LSB = 4;
  localparam int BWP_W = 3;
  localparam int PERF_BIT = 7;
  localparam int RANGE_W = 2;

  // fill counter split across two bytes
  localparam int FILL_W = 14;
  localparam int FILL_HI_W = 6;

  // status byte layout
  localparam int MSG_W = 5;
  localparam int REMAP_BIT = 5;
  localparam int LOW_RATE_BIT = 6;
  localparam int TAP_RATE_BIT = 7;

  // output rate codes
  localparam logic [3:0] ODR_MIN_CODE = 4'h1;
  localparam logic [3:0] ODR_MAX_CODE = 4'hC;
  localparam logic [3:0] ODR_50HZ_CODE = 4'h7;
  localparam logic [3:0] ODR_100HZ_CODE = 4'h8;

  // bandwidth codes in continuous filter mode
  localparam logic [2:0] BWP_OSR4 = 3'h0;
  localparam logic [2:0] BWP_OSR2 = 3'h1;
  localparam logic [2:0] BWP_NORMAL = 3'h2;

  // AHB transfer type bit that marks an active transfer, and the OKAY response code
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // internal status message codes
  typedef enum logic [MSG_W-1:0] {
    MSG_NOT_INIT = 5'h00,
    MSG_INIT_OK = 5'h01,
    MSG_INIT_ERR = 5'h02,
    MSG_DRV_ERR = 5'h03,
    MSG_SNS_STOP = 5'h04
  } status_msg_t;

  // effective filter behaviour decoded from the configuration
  typedef enum logic [2:0] {
    FILT_OSR4 = 3'h0,
    FILT_OSR2 = 3'h1,
    FILT_NORMAL = 3'h3,
    FILT_AVERAGE = 3'h2,
    FILT_RESERVED = 3'h6
  } filter_mode_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

endpackage

/* config_fault_eval.sv */
// Purpose: judges the configured output rate against feature needs and builds the status byte
// Assumes: feature enables and remap fault come from the sensor core as steady levels
// Notes: flags are levels that follow the configuration, registered once
`timescale 1ns/1ns
module config_fault_eval #(
  parameter logic [3:0] TAP_MIN_CODE = 4'h9
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [accel_regs_pkg::ODR_W-1:0] odr_code,
  input wire logic [accel_regs_pkg::MSG_W-1:0] status_msg,
  input wire logic remap_fault,
  input wire logic feature_50hz_en,
  input wire logic tap_en,
  output logic [accel_regs_pkg::BYTE_W-1:0] status_q
);
  import accel_regs_pkg::*;

  logic [BYTE_W-1:0] status_d;

  // rate checks compare codes; higher code means faster rate
  always_comb begin
    status_d = BYTE_ZERO;
    status_d[MSG_W-1:0] = status_msg;
    status_d[REMAP_BIT] = remap_fault;
    status_d[LOW_RATE_BIT] = feature_50hz_en && (odr_code < ODR_50HZ_CODE);
    status_d[TAP_RATE_BIT] = tap_en && (odr_code < TAP_MIN_CODE);
  end

  // registered so the read mux sees a clean byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= BYTE_ZERO;
    end else begin
      status_q <= status_d;
    end
  end

endmodule // config_fault_eval

/* accel_cfg_chk.sv */
// Purpose: port checks of the register bank
// Assumes: zero-wait slave, one clock
// Notes: bound to the top module below the checker
`timescale 1ns/1ns
module accel_cfg_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [9:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic fifo_head_valid,
  input wire logic fifo_pop,
  input wire logic [3:0] odr_sel,
  input wire logic odr_code_reserved,
  input wire logic perf_mode,
  input wire logic [2:0] bwp_sel,
  input wire accel_regs_pkg::filter_mode_t filter_mode,
  input wire logic [2:0] avg_log2,
  input wire logic [1:0] range_sel
);
  import accel_regs_pkg::*;
  logic wr_q;
  logic rd_q;
  logic port_rd;
  assign port_rd = hsel && htrans[1] && !hwrite && haddr == {IDX_FIFO_PORT, 2'h0};
  // accepted requests, one cycle late to line up with their effects
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= hsel && htrans[1] && hwrite;
      rd_q <= hsel && htrans[1] && !hwrite;
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bad bus answer");
  pop_cause_a: assert property (fifo_pop |-> port_rd && fifo_head_valid)
    else $error("stray pop");
  pop_made_a: assert property (port_rd && fifo_head_valid |-> fifo_pop)
    else $error("missed pop");
  odr_resv_a: assert property
    (odr_code_reserved == (odr_sel == 4'h0 || odr_sel > ODR_MAX_CODE)) else $error("bad flag");
  avg_exp_a: assert property (avg_log2 == (perf_mode ? 3'h0 : bwp_sel))
    else $error("bad exponent");
  filt_avg_a: assert property (!perf_mode |-> filter_mode == FILT_AVERAGE)
    else $error("bad filter");
  filt_resv_a: assert property
    (perf_mode && bwp_sel > BWP_NORMAL |-> filter_mode == FILT_RESERVED) else $error("bad filter");
  cfg_hold_a: assert property ($changed(odr_sel) || $changed(range_sel) |-> $past(wr_q))
    else $error("config moved unwritten");
  rdata_hold_a: assert property ($changed(hrdata) |-> rd_q)
    else $error("read data moved unread");
endmodule // accel_cfg_chk
bind accel_config_status_regs accel_cfg_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hreadyout, .hresp, .hrdata, .fifo_head_valid, .fifo_pop, .odr_sel,
  .odr_code_reserved, .perf_mode, .bwp_sel, .filter_mode, .avg_log2, .range_sel);

/* fifo_src_model.sv */
// Purpose: byte source behind the FIFO read port
// Assumes: at most 16 bytes queued
// Notes: empty head shows the inverse of the last byte, never a stale copy
`timescale 1ns/1ns
module fifo_src_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push,
  input wire logic [7:0] push_byte,
  input wire logic [13:0] fill_extra,
  input wire logic fifo_pop,
  output logic [13:0] fifo_fill_level,
  output logic [7:0] fifo_head_byte,
  output logic fifo_head_valid
);
  logic [7:0] mem [0:15];
  logic [4:0] rd_q, wr_q;
  // queue pointers; next head ready one cycle after a pop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 5'h00;
      wr_q <= 5'h00;
    end else begin
      if (push) begin
        mem[wr_q[3:0]] <= push_byte;
        wr_q <= wr_q + 5'h01;
      end
      if (fifo_pop && fifo_head_valid) rd_q <= rd_q + 5'h01;
    end
  end
  assign fifo_head_valid = rd_q != wr_q;
  assign fifo_fill_level = fill_extra + {9'h000, wr_q - rd_q};
  assign fifo_head_byte = fifo_head_valid ? mem[rd_q[3:0]] : ~mem[rd_q[3:0] - 4'h1];
endmodule // fifo_src_model

/* tb.sv */
// Purpose: self-checking bench of the register bank
// Assumes: one AHB-Lite master, one register per word at index*4
// Notes: tap threshold set here; status expectations follow it
`timescale 1ns/1ns
module tb;
  import accel_regs_pkg::*;
  localparam logic [3:0] TAP_MIN = 4'h9;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, fifo_pop, fifo_head_valid, push;
  logic remap_fault, feature_50hz_en, tap_en, odr_code_reserved, perf_mode;
  logic [9:0] haddr;
  logic [1:0] htrans, range_sel;
  logic [2:0] hsize, bwp_sel, avg_log2;
  logic [31:0] hwdata, hrdata, r;
  logic [13:0] fifo_fill_level, fill_extra;
  logic [7:0] fifo_head_byte, activity_code, push_byte;
  logic [4:0] status_msg;
  logic [3:0] odr_sel;
  filter_mode_t filter_mode;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  assign hready = hreadyout;
  accel_config_status_regs #(.TAP_MIN_CODE(TAP_MIN)) uut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .fifo_fill_level,
    .fifo_head_byte, .fifo_head_valid, .fifo_pop, .activity_code, .status_msg, .remap_fault,
    .feature_50hz_en, .tap_en, .odr_sel, .odr_code_reserved, .perf_mode, .bwp_sel,
    .filter_mode, .avg_log2, .range_sel);
  fifo_src_model src (.hclk, .hresetn, .push, .push_byte, .fill_extra, .fifo_pop,
    .fifo_fill_level, .fifo_head_byte, .fifo_head_valid);
  // clock, and a cycle ceiling that cuts a hang short
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one single transfer; read data taken at the edge closing the data phase
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {idx, 2'h0};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, r);
  endtask
  task automatic t_reset();
    rc("rate", IDX_RATE_CFG, 32'hA8);
    rc("range", IDX_RANGE, 32'h01);
    rc("fill", IDX_FILL_LO, 32'h0);
    rc("status", IDX_STATUS, 32'h0);
    rc("port", IDX_FIFO_PORT, 32'h0);
    chk("odr_sel", 32'h8, odr_sel);
  endtask
  // all rate codes, each paired with one bandwidth code; all bandwidth codes in both filter modes
  task automatic t_cfg();
    logic [7:0] v;
    filter_mode_t f;
    for (int k = 0; k < 16; k++) begin
      v = {k[3], k[2:0], k[3:0]};
      bus(1'b1, IDX_RATE_CFG, {24'hFFFFFF, v});
      #1;
      f = !v[7] ? FILT_AVERAGE : v[6:4] == 3'h0 ? FILT_OSR4 : v[6:4] == 3'h1 ? FILT_OSR2
        : v[6:4] == 3'h2 ? FILT_NORMAL : FILT_RESERVED;
      chk("odr_sel", v[3:0], odr_sel);
      chk("resv", k == 0 || k > 12, odr_code_reserved);
      chk("filter", f, filter_mode);
      chk("avg", v[7] ? 3'h0 : v[6:4], avg_log2);
      rc("rate", IDX_RATE_CFG, v);
    end
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, IDX_RANGE, 32'hFC + k);
      rc("range", IDX_RANGE, k);
      chk("range_sel", k, range_sel);
    end
  endtask
  // read-only and unmapped places ignore writes
  task automatic t_ro();
    fill_extra <= 14'h3ABC;
    bus(1'b1, IDX_FILL_LO, 32'hFF);
    bus(1'b1, IDX_STATUS, 32'hFF);
    bus(1'b1, 8'hFF, 32'hFF);
    bus(1'b1, IDX_ACTIVITY, 32'hFF);
    rc("activity", IDX_ACTIVITY, 32'h5A);
    rc("fill_lo", IDX_FILL_LO, 32'hBC);
    rc("fill_hi", IDX_FILL_HI, 32'h3A);
    rc("status", IDX_STATUS, 32'h0);
    rc("unmapped", 8'hFF, 32'h0);
    fill_extra <= 14'h0;
  endtask
  // every message code and fault flag at a slow and a middle rate
  task automatic t_status();
    logic [3:0] o;
    logic [7:0] e;
    for (int k = 0; k < 16; k++) begin
      o = k[3] ? ODR_100HZ_CODE : 4'h6;
      bus(1'b1, IDX_RATE_CFG, {28'h0, o});
      status_msg <= 5'(k % 5);
      {tap_en, feature_50hz_en, remap_fault} <= k[2:0];
      repeat (2) @(posedge hclk);
      e = {k[2] && o < TAP_MIN, k[1] && o < ODR_50HZ_CODE, k[0], 5'(k % 5)};
      rc("status", IDX_STATUS, {24'h0, e});
    end
  endtask
  // three bytes through the one port, then the empty port
  task automatic t_stream();
    for (int k = 0; k < 3; k++) begin
      @(posedge hclk);
      push <= 1'b1;
      push_byte <= 8'hC3 + 8'(k);
    end
    @(posedge hclk);
    push <= 1'b0;
    rc("fill", IDX_FILL_LO, 32'h3);
    for (int k = 0; k < 3; k++) rc("port", IDX_FIFO_PORT, 32'hC3 + k);
    rc("empty", IDX_FIFO_PORT, 32'h0);
    rc("fill", IDX_FILL_LO, 32'h0);
  endtask
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, push, remap_fault, feature_50hz_en, tap_en} = '0;
    {haddr, htrans, hwdata, push_byte, fill_extra, status_msg} = '0;
    hsize = 3'h2;
    activity_code = 8'h5A;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_cfg();
    t_ro();
    t_status();
    t_stream();
    {status_msg, remap_fault, feature_50hz_en, tap_en} <= '0;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    conclude();
  end
endmodule // tb
